// [design/dcf_pkg.sv]
// Package: states, strap codes, reset values and widths of the dual-cpu flush handshake
package dcf_pkg;

    // ****************************************
    // Ratio straps {ratio_select_hi, ratio_select_lo}
    // ****************************************
    localparam logic [1:0] DCF_RATIO_1_3 = 2'h1;
    localparam logic [1:0] DCF_RATIO_2_5 = 2'h0;
    localparam logic [1:0] DCF_RATIO_1_2 = 2'h2;
    localparam logic [1:0] DCF_RATIO_2_7 = 2'h3;
    localparam logic [1:0] DCF_RATIO_RESET = DCF_RATIO_1_2;

    // ****************************************
    // Reset values and widths
    // ****************************************
    localparam int DCF_CNT_W = 16;
    localparam logic [15:0] DCF_CNT_RESET = 16'h0000;
    localparam logic DCF_CORE_DOUBLE_RESET = 1'h1;

    // ****************************************
    // Handshake states
    // ****************************************
    typedef enum logic [2:0] {
        DCF_IDLE,
        DCF_HANDOFF,
        DCF_SEC_FLUSH,
        DCF_RETURN,
        DCF_PRI_FLUSH,
        DCF_PRI_ACK,
        DCF_SEC_WAIT
    } dcf_state_e;

endpackage

// [design/dcf_flush_if.sv]
// Interface: request and done between the handshake and its flush sequencer
`timescale 1ns/1ps
interface dcf_flush_if;
    logic start;
    logic done;
    modport ctrl (output start, input done);
    modport seq (input start, output done);
endinterface

// [design/dcf_flush_seq.sv]
// Flush sequencer: walks every cache line once, writing back and invalidating it
`timescale 1ns/1ps
module dcf_flush_seq
    import dcf_pkg::*;
#(
    parameter int LINES = 256
) (
    // ****************************************
    // Clock and reset
    // ****************************************
    input wire logic i_clock,
    input wire logic i_rst,
    // ****************************************
    // Handshake
    // ****************************************
    dcf_flush_if.seq flush,
    // ****************************************
    // Cache line operation
    // ****************************************
    output logic o_line_op,
    output logic [DCF_CNT_W-1:0] o_line_index
);
    logic busy;
    logic next_busy;
    logic done;
    logic next_done;
    logic [DCF_CNT_W-1:0] idx;
    logic [DCF_CNT_W-1:0] next_idx;

    always_comb begin
        next_busy = busy;
        next_idx = idx;
        next_done = 1'b0;
        if (!busy && flush.start && !done) begin
            next_busy = 1'b1;
            next_idx = DCF_CNT_RESET;
        end else if (busy) begin
            if (idx == DCF_CNT_W'(LINES - 1)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_idx = idx + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            idx <= DCF_CNT_RESET;
        end else begin
            busy <= next_busy;
            done <= next_done;
            idx <= next_idx;
        end
    end

    assign flush.done = done;
    assign o_line_op = busy;
    assign o_line_index = idx;
endmodule

// [design/dcf_handshake.sv]
// Top: dual-processor cache flush handshake and bus-ratio strap decode
`timescale 1ns/1ps
module dcf_handshake
    import dcf_pkg::*;
#(
    parameter int LINES = 256
) (
    // ****************************************
    // Clock and reset
    // ****************************************
    input wire logic i_clock,
    input wire logic i_rst,
    // ****************************************
    // Straps and mode
    // ****************************************
    input wire logic i_ratio_select_hi,
    input wire logic i_ratio_select_lo,
    input wire logic i_dual_processor_mode,
    // ****************************************
    // System flush request and bus
    // ****************************************
    input wire logic i_flush_req,
    input wire logic i_flush_ack_cycle,
    input wire logic i_pri_flush_done,
    // ****************************************
    // Bus ownership and status
    // ****************************************
    output logic o_sec_owns_bus,
    output logic o_sec_bus_req,
    output logic o_sec_flushing,
    output logic o_sec_waiting,
    output logic o_pri_flush_start,
    output logic o_flush_ack_cycle,
    output logic o_flush_busy,
    output logic [1:0] o_ratio,
    output logic o_core_double,
    output logic o_ratio_hazard,
    output logic o_line_op,
    output logic [DCF_CNT_W-1:0] o_line_index
);
    // ****************************************
    // Strap capture
    // ****************************************
    logic [1:0] ratio;
    logic [1:0] next_ratio;

    // Straps float to the 1/2 code; sampled every cycle of reset, frozen after
    always_comb begin
        next_ratio = ratio;
        if (i_rst) begin
            next_ratio = {i_ratio_select_hi, i_ratio_select_lo};
        end
    end

    // Synchronous capture with no reset branch; reset loads no constant into ratio
    always_ff @(posedge i_clock) begin
        ratio <= next_ratio;
    end

    // ****************************************
    // Handshake state machine
    // ****************************************
    dcf_flush_if fif ();
    dcf_state_e state;
    dcf_state_e next_state;
    logic sec_owns;
    logic next_sec_owns;
    logic sec_req;
    logic next_sec_req;
    logic flushing;
    logic next_flushing;
    logic waiting;
    logic next_waiting;
    logic pri_start;
    logic next_pri_start;
    logic ack_out;
    logic next_ack_out;
    logic busy;
    logic next_busy;
    logic core_double;
    logic hazard;
    logic next_core_double;
    logic next_hazard;

    always_comb begin
        next_state = state;
        next_sec_owns = 1'b0;
        next_sec_req = 1'b0;
        next_flushing = 1'b0;
        next_waiting = 1'b0;
        next_pri_start = 1'b0;
        next_ack_out = 1'b0;
        next_busy = 1'b1;
        case (state)
            DCF_IDLE: begin
                next_busy = 1'b0;
                if (i_flush_req && i_dual_processor_mode) begin
                    next_state = DCF_HANDOFF;
                    next_busy = 1'b1;
                end
            end
            DCF_HANDOFF: begin
                next_sec_owns = 1'b1;
                next_flushing = 1'b1;
                next_state = DCF_SEC_FLUSH;
            end
            DCF_SEC_FLUSH: begin
                next_sec_owns = 1'b1;
                next_flushing = 1'b1;
                if (fif.done) begin
                    next_sec_owns = 1'b0;
                    next_flushing = 1'b0;
                    next_waiting = 1'b1;
                    next_state = DCF_RETURN;
                end
            end
            DCF_RETURN: begin
                next_waiting = 1'b1;
                next_pri_start = 1'b1;
                next_state = DCF_PRI_FLUSH;
            end
            DCF_PRI_FLUSH: begin
                next_waiting = 1'b1;
                if (i_pri_flush_done) begin
                    next_ack_out = 1'b1;
                    next_state = DCF_PRI_ACK;
                end
            end
            DCF_PRI_ACK: begin
                next_waiting = 1'b1;
                next_state = DCF_SEC_WAIT;
            end
            DCF_SEC_WAIT: begin
                next_waiting = 1'b1;
                if (i_flush_ack_cycle || ack_out) begin
                    next_waiting = 1'b0;
                    next_busy = 1'b0;
                    next_sec_req = 1'b1;
                    next_state = DCF_IDLE;
                end
            end
            default: begin
                next_state = DCF_IDLE;
                next_busy = 1'b0;
            end
        endcase
        // Bus request only allowed outside the flush sequence
        if (next_waiting || next_sec_owns) begin
            next_sec_req = 1'b0;
        end
        // Strap decode and hazard report
        next_core_double = (ratio == DCF_RATIO_1_2);
        next_hazard = i_flush_req && i_dual_processor_mode && (ratio == DCF_RATIO_2_7);
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state <= DCF_IDLE;
            sec_owns <= 1'b0;
            sec_req <= 1'b0;
            flushing <= 1'b0;
            waiting <= 1'b0;
            pri_start <= 1'b0;
            ack_out <= 1'b0;
            busy <= 1'b0;
            core_double <= DCF_CORE_DOUBLE_RESET;
            hazard <= 1'b0;
        end else begin
            state <= next_state;
            sec_owns <= next_sec_owns;
            sec_req <= next_sec_req;
            flushing <= next_flushing;
            waiting <= next_waiting;
            pri_start <= next_pri_start;
            ack_out <= next_ack_out;
            busy <= next_busy;
            core_double <= next_core_double;
            hazard <= next_hazard;
        end
    end

    // ****************************************
    // Flush sequencer
    // ****************************************
    // Secondary's own L1 walk
    assign fif.start = (state == DCF_SEC_FLUSH);

    dcf_flush_seq #(
        .LINES(LINES)
    ) u_seq (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .flush(fif.seq),
        .o_line_op(o_line_op),
        .o_line_index(o_line_index)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign o_sec_owns_bus = sec_owns;
    assign o_sec_bus_req = sec_req;
    assign o_sec_flushing = flushing;
    assign o_sec_waiting = waiting;
    assign o_pri_flush_start = pri_start;
    assign o_flush_ack_cycle = ack_out;
    assign o_flush_busy = busy;
    assign o_ratio = ratio;
    assign o_core_double = core_double;
    assign o_ratio_hazard = hazard;
endmodule

// [tb/dcf_assertions.sv]
// Checker: flush handshake ownership and ordering properties
`timescale 1ns/1ps
module dcf_assertions (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Request side
    input wire logic i_flush_req,
    input wire logic i_dual_processor_mode,
    // Handshake outputs
    input wire logic o_flush_busy,
    input wire logic o_sec_owns_bus,
    input wire logic o_sec_flushing,
    input wire logic o_sec_waiting,
    input wire logic o_sec_bus_req,
    input wire logic o_pri_flush_start,
    input wire logic o_flush_ack_cycle,
    input wire logic o_line_op
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    property p_take;
        i_flush_req && i_dual_processor_mode && !o_flush_busy |=> o_flush_busy ##1 o_sec_owns_bus;
    endproperty
    a_take: assert property (p_take) else $error("flush not taken");
    property p_flush;
        $rose(o_sec_owns_bus) |-> o_sec_flushing ##1 o_line_op;
    endproperty
    a_flush: assert property (p_flush) else $error("flush walk missing");
    property p_line;
        o_line_op |-> o_sec_owns_bus && o_sec_flushing;
    endproperty
    a_line: assert property (p_line) else $error("line op without bus");
    property p_ret;
        $fell(o_sec_owns_bus) |-> o_sec_waiting && !o_sec_flushing ##1 o_pri_flush_start;
    endproperty
    a_ret: assert property (p_ret) else $error("bus not returned");
    property p_quiet;
        o_sec_waiting |-> !o_sec_bus_req && !o_sec_owns_bus;
    endproperty
    a_quiet: assert property (p_quiet) else $error("request while waiting");
    property p_start;
        o_pri_flush_start || o_flush_ack_cycle |-> o_sec_waiting && !o_sec_owns_bus;
    endproperty
    a_start: assert property (p_start) else $error("primary flush out of order");
    property p_exit;
        o_flush_ack_cycle |-> ##[1:3] $fell(o_sec_waiting);
    endproperty
    a_exit: assert property (p_exit) else $error("wait not left");
    property p_resume;
        $fell(o_sec_waiting) |-> o_sec_bus_req && !o_flush_busy;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume");
    c_resume: cover property ($fell(o_sec_waiting));
    c_refused: cover property (i_flush_req && !i_dual_processor_mode);
    c_walk: cover property (o_line_op ##1 !o_line_op);
endmodule
bind dcf_handshake dcf_assertions u_chk (.i_clock, .i_rst, .i_flush_req, .i_dual_processor_mode,
    .o_flush_busy, .o_sec_owns_bus, .o_sec_flushing, .o_sec_waiting, .o_sec_bus_req,
    .o_pri_flush_start, .o_flush_ack_cycle, .o_line_op);

// [tb/dcf_partner.sv]
// Partner model: primary processor flush time and bus view of its acknowledge
`timescale 1ns/1ps
module dcf_partner (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Flush handshake
    input wire logic i_start,
    input wire logic i_ack,
    input wire logic [3:0] i_delay,
    output logic o_done,
    output logic o_ack_seen
);
    logic [4:0] cnt;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 5'h00;
            o_done <= 1'b0;
            o_ack_seen <= 1'b0;
        end else begin
            o_ack_seen <= i_ack;
            o_done <= (cnt == 5'h01);
            if (i_start) begin
                cnt <= {1'b0, i_delay} + 5'h01;
            end else if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
            end
        end
    end
endmodule

// [tb/dcf_handshake_tb_top.sv]
// Testbench: random flush walks and strap capture against the partner model
`timescale 1ns/1ps
module dcf_handshake_tb_top;
    localparam int NL = 5;
    logic i_clock, i_rst, i_ratio_select_hi, i_ratio_select_lo, i_dual_processor_mode;
    logic i_flush_req, i_flush_ack_cycle, i_pri_flush_done, o_sec_owns_bus, o_sec_bus_req;
    logic o_sec_flushing, o_sec_waiting, o_pri_flush_start, o_flush_ack_cycle, o_flush_busy;
    logic o_core_double, o_ratio_hazard, o_line_op;
    logic [1:0] o_ratio;
    logic [dcf_pkg::DCF_CNT_W-1:0] o_line_index;
    logic [3:0] delay;
    logic [1:0] strap_code;
    int seed = 32'h155A;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    dcf_handshake #(.LINES(NL)) DUT (.i_clock, .i_rst, .i_ratio_select_hi, .i_ratio_select_lo,
        .i_dual_processor_mode, .i_flush_req, .i_flush_ack_cycle, .i_pri_flush_done,
        .o_sec_owns_bus, .o_sec_bus_req, .o_sec_flushing, .o_sec_waiting, .o_pri_flush_start,
        .o_flush_ack_cycle, .o_flush_busy, .o_ratio, .o_core_double, .o_ratio_hazard,
        .o_line_op, .o_line_index);
    dcf_partner PEER (.i_clock, .i_rst, .i_start(o_pri_flush_start), .i_ack(o_flush_ack_cycle),
        .i_delay(delay), .o_done(i_pri_flush_done), .o_ack_seen(i_flush_ack_cycle));
    function automatic int exp_lines(input logic dual);
        return dual ? NL : 0;
    endfunction
    function automatic logic exp_hazard(input logic dual);
        return dual && (strap_code == dcf_pkg::DCF_RATIO_2_7);
    endfunction
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic straps(input logic [1:0] code);
        strap_code = code;
        @(posedge i_clock);
        i_rst <= 1'b1;
        {i_ratio_select_hi, i_ratio_select_lo} <= code;
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        {i_ratio_select_hi, i_ratio_select_lo} <= 2'($random(seed));
        repeat (2) @(negedge i_clock);
        chk("ratio", 16'(code), 16'(o_ratio));
        chk("core_double", 16'(code == dcf_pkg::DCF_RATIO_1_2), 16'(o_core_double));
    endtask
    task automatic run_flush(input logic dual);
        int n;
        int b;
        int p;
        int a;
        n = 0;
        b = 0;
        p = 0;
        a = 0;
        @(posedge i_clock);
        i_dual_processor_mode <= dual;
        i_flush_req <= 1'b1;
        delay <= 4'($random(seed));
        @(posedge i_clock);
        i_flush_req <= 1'b0;
        for (int k = 0; k < 300; k++) begin
            @(negedge i_clock);
            if (k < 2)
                chk("hazard", 16'(k == 0 && exp_hazard(dual)), 16'(o_ratio_hazard));
            if (o_line_op === 1'b1) begin
                chk("line_index", 16'(n), o_line_index);
                n++;
            end
            b += int'(o_sec_bus_req === 1'b1);
            p += int'(o_pri_flush_start === 1'b1);
            a += int'(o_flush_ack_cycle === 1'b1);
            if (k > 2 && o_flush_busy !== 1'b1)
                break;
        end
        chk("line_count", 16'(exp_lines(dual)), 16'(n));
        chk("resume_req", 16'(dual), 16'(b));
        chk("busy", 16'h0000, 16'(o_flush_busy));
        chk("pri_start", 16'(dual), 16'(p));
        chk("ack_cycle", 16'(dual), 16'(a));
    endtask
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        i_rst = 1'b1;
        {i_ratio_select_hi, i_ratio_select_lo} = 2'h2;
        i_dual_processor_mode = 1'b0;
        i_flush_req = 1'b0;
        delay = 4'h0;
        for (int c = 0; c < 4; c++) begin
            straps(2'(c));
            for (int r = 0; r < 3; r++)
                run_flush(c != 3 && r != 1);
        end
        close_out();
    end
endmodule
